// ===== shared/srcp_pkg.sv
package srcp_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PCHAR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RESP = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_ERRQ = 8'h10;
    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SET_LSB = 4;
    localparam int CMD_KIND_LSB = 6;
    localparam int CMD_FMT_LSB = 8;
    localparam logic [3:0] OP_CLS = 4'h1;
    localparam logic [3:0] OP_STAT_PRESET = 4'h2;
    localparam logic [3:0] OP_RST = 4'h3;
    localparam logic [3:0] OP_SYS_PRESET = 4'h4;
    localparam logic [3:0] OP_QUEUE_CLR = 4'h5;
    localparam logic [3:0] OP_ERR_CLR = 4'h6;
    localparam logic [3:0] OP_PROGRAM = 4'h7;
    localparam logic [3:0] OP_QUERY = 4'h8;
    localparam logic [3:0] OP_FORMAT = 4'h9;
    // Register sets and kinds
    localparam logic [1:0] SET_STD = 2'h0;
    localparam logic [1:0] KIND_COND = 2'h0;
    localparam logic [1:0] KIND_EVENT = 2'h1;
    localparam logic [1:0] KIND_ENABLE = 2'h2;
    localparam int NUM_SETS = 4;
    // Status and pop word fields
    localparam int ST_FMT_LSB = 0;
    localparam int ST_PERR_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_RCNT_LSB = 8;
    localparam int ST_ECNT_LSB = 16;
    localparam int RESP_VALID_BIT = 8;
    localparam int ERRQ_VALID_BIT = 16;
    // Characters
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_B = 8'h42;
    localparam logic [7:0] CH_H = 8'h48;
    localparam logic [7:0] CH_Q = 8'h51;
    localparam logic [7:0] CASE_BIT = 8'h20;
    // Error codes
    localparam logic [15:0] ERR_BAD_DIGIT = 16'h0001;
    localparam logic [15:0] ERR_BAD_HEADER = 16'h0002;
    localparam logic [15:0] ERR_NO_DIGITS = 16'h0003;
    localparam logic [15:0] ERR_READ_ONLY = 16'h0004;
    localparam logic [15:0] ERR_BAD_CMD = 16'h0005;
    localparam logic [15:0] ERR_BUSY = 16'h0006;
    // Digit counts for a 16-bit value
    localparam logic [4:0] DIGITS_DEC = 5'd5;
    localparam logic [4:0] DIGITS_HEX = 5'd4;
    localparam logic [4:0] DIGITS_OCT = 5'd6;
    localparam logic [4:0] DIGITS_BIN = 5'd16;
    typedef enum logic [1:0] {
        FMT_ASC = 2'h0,
        FMT_HEX = 2'h1,
        FMT_OCT = 2'h2,
        FMT_BIN = 2'h3
    } srcp_fmt_t;
    typedef enum logic [3:0] {
        PS_START = 4'b0001,
        PS_HEADER = 4'b0010,
        PS_NDN = 4'b0100,
        PS_DEC = 4'b1000
    } srcp_pstate_t;
    typedef enum logic [3:0] {
        RG_IDLE = 4'b0001,
        RG_HASH = 4'b0010,
        RG_LETTER = 4'b0100,
        RG_DIGIT = 4'b1000
    } srcp_rgen_t;
endpackage

// ===== rtl/srcp_status_regs.sv
// How it works
// - Reset clears all event and enable registers and empties both queues.
// - Instrument reset and system preset commands leave status state alone.
// - Clear-status and status preset zero all four event registers.
// - They also zero operation, measurement and questionable enables.
// - Standard event enable changes only through its own program command.
// - Status preset keeps the error queue contents.
// - Clear-status empties the error queue.
// - Queue clear and error clear commands each empty the error queue.
// - Programming an enable register with zero clears it.
// - Only enable registers accept writes; others are read-only.
// - Each parameter bit sets the matching enable bit to 0 or 1.
// - Registers are 16 bits, bit n weighing two to the n.
// - Parameters may be binary, decimal, hexadecimal or octal.
// - Non-decimal parameters start with #B, #H or #Q.
// - The radix letter is accepted in either case.
// - Decimal parameters carry no prefix.
// - Digits are limited to those valid for the radix.
// - A query returns the current contents of any status register.
// - The answer's binary form marks exactly the set bits.
// - Response radix is selectable, decimal after reset.
// - Non-decimal responses are prefixed with #B, #H or #Q.
`timescale 1ns/1ns
module srcp_status_regs #(
    parameter int ERRQ_DEPTH = 8,
    parameter int RESP_DEPTH = 20
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [srcp_pkg::ADDR_W-1:0] paddr,
    input wire logic [srcp_pkg::DATA_W-1:0] pwdata,
    output logic [srcp_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [srcp_pkg::REG_W-1:0] operCond,
    input wire logic [srcp_pkg::REG_W-1:0] measCond,
    input wire logic [srcp_pkg::REG_W-1:0] quesCond,
    input wire logic [srcp_pkg::REG_W-1:0] stdEvtSet,
    input wire logic [srcp_pkg::REG_W-1:0] operEvtSet,
    input wire logic [srcp_pkg::REG_W-1:0] measEvtSet,
    input wire logic [srcp_pkg::REG_W-1:0] quesEvtSet,
    input wire logic errPushValid,
    input wire logic [15:0] errPushCode
);
    import srcp_pkg::*;

    localparam int EQ_AW = $clog2(ERRQ_DEPTH);
    localparam int RS_AW = $clog2(RESP_DEPTH + 1);

    function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
        return a == OFF_CMD || a == OFF_PCHAR || a == OFF_RESP ||
            a == OFF_STATUS || a == OFF_ERRQ;
    endfunction

    // Returns {isDigit, value} for 0-9 and A-F in either case
    function automatic logic [4:0] charVal(input logic [7:0] c);
        logic [7:0] u;
        u = c & ~CASE_BIT;
        if (c >= CH_0 && c <= CH_9) begin
            return {1'b1, 4'(c - CH_0)};
        end
        if (u >= CH_A && u <= CH_F) begin
            return {1'b1, 4'(u - CH_A + 8'd10)};
        end
        return 5'h00;
    endfunction

    function automatic logic [4:0] radixOf(input srcp_fmt_t f);
        case (f)
            FMT_HEX: return 5'd16;
            FMT_OCT: return 5'd8;
            FMT_BIN: return 5'd2;
            default: return 5'd10;
        endcase
    endfunction

    function automatic logic [2:0] bitsOf(input srcp_fmt_t f);
        case (f)
            FMT_HEX: return 3'd4;
            FMT_OCT: return 3'd3;
            default: return 3'd1;
        endcase
    endfunction

    function automatic logic [4:0] digitsOf(input srcp_fmt_t f);
        case (f)
            FMT_HEX: return DIGITS_HEX;
            FMT_OCT: return DIGITS_OCT;
            FMT_BIN: return DIGITS_BIN;
            default: return DIGITS_DEC;
        endcase
    endfunction

    function automatic logic [REG_W-1:0] pow10(input logic [4:0] p);
        case (p)
            5'd4: return 16'd10000;
            5'd3: return 16'd1000;
            5'd2: return 16'd100;
            5'd1: return 16'd10;
            default: return 16'd1;
        endcase
    endfunction

    // APB decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wrAcc = access & pwrite;
    wire rdAcc = access & ~pwrite;
    wire cmdWr = wrAcc & (paddr == OFF_CMD);
    wire charWr = wrAcc & (paddr == OFF_PCHAR);
    wire [3:0] op = pwdata[CMD_OP_LSB +: 4];
    wire [1:0] cmdSet = pwdata[CMD_SET_LSB +: 2];
    wire [1:0] cmdKind = pwdata[CMD_KIND_LSB +: 2];
    wire [7:0] ch = pwdata[7:0];

    assign pready = 1'b1;
    assign pslverr = access & ~addrMapped(paddr);

    // Instrument reset and system preset opcodes are decoded but touch nothing here
    wire opKnown = (op >= OP_CLS) && (op <= OP_FORMAT);
    wire clrEvents = cmdWr & (op == OP_CLS || op == OP_STAT_PRESET);
    wire errClr = cmdWr & (op == OP_CLS || op == OP_QUEUE_CLR ||
        op == OP_ERR_CLR);

    // Parser state
    srcp_pstate_t ps_ff, nxt_ps;
    srcp_fmt_t pfmt_ff, nxt_pfmt;
    logic [REG_W-1:0] acc_ff, nxt_acc;
    logic got_ff, nxt_got, perr_ff, nxt_perr;
    logic [15:0] perrCode_ff, nxt_perrCode;

    wire [4:0] cv = charVal(ch);
    wire digitOk = cv[4] && ({1'b0, cv[3:0]} < radixOf(pfmt_ff));
    wire [19:0] accWide = 20'(acc_ff);
    wire [19:0] accDec = (accWide << 3) + (accWide << 1) + 20'(cv[3:0]);
    wire [19:0] accP2 = (accWide << bitsOf(pfmt_ff)) | 20'(cv[3:0]);
    wire [REG_W-1:0] accNext = (pfmt_ff == FMT_ASC) ? accDec[REG_W-1:0] :
        accP2[REG_W-1:0];
    wire [7:0] upper = ch & ~CASE_BIT;

    wire progCmd = cmdWr & (op == OP_PROGRAM);
    wire paramGood = ~perr_ff & (ps_ff == PS_DEC ||
        (ps_ff == PS_NDN && got_ff));
    wire progOk = progCmd & (cmdKind == KIND_ENABLE) & paramGood;

    always_comb begin
        nxt_ps = ps_ff;
        nxt_pfmt = pfmt_ff;
        nxt_acc = acc_ff;
        nxt_got = got_ff;
        nxt_perr = perr_ff;
        nxt_perrCode = perrCode_ff;
        if (progCmd) begin
            nxt_ps = PS_START;
            nxt_pfmt = FMT_ASC;
            nxt_acc = '0;
            nxt_got = 1'b0;
            nxt_perr = 1'b0;
        end else if (charWr && !perr_ff) begin
            case (ps_ff)
                PS_START: begin
                    if (ch == CH_HASH) begin
                        nxt_ps = PS_HEADER;
                    end else if (digitOk) begin
                        nxt_ps = PS_DEC;
                        nxt_acc = accNext;
                        nxt_got = 1'b1;
                    end else if (ch != CH_SPACE) begin
                        nxt_perr = 1'b1;
                        nxt_perrCode = ERR_BAD_DIGIT;
                    end
                end
                PS_HEADER: begin
                    nxt_ps = PS_NDN;
                    if (upper == CH_B) begin
                        nxt_pfmt = FMT_BIN;
                    end else if (upper == CH_H) begin
                        nxt_pfmt = FMT_HEX;
                    end else if (upper == CH_Q) begin
                        nxt_pfmt = FMT_OCT;
                    end else begin
                        nxt_perr = 1'b1;
                        nxt_perrCode = ERR_BAD_HEADER;
                    end
                end
                PS_NDN, PS_DEC: begin
                    if (digitOk) begin
                        nxt_acc = accNext;
                        nxt_got = 1'b1;
                    end else begin
                        nxt_perr = 1'b1;
                        nxt_perrCode = ERR_BAD_DIGIT;
                    end
                end
                default: nxt_ps = PS_START;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ps_ff <= PS_START;
            pfmt_ff <= FMT_ASC;
            acc_ff <= '0;
            got_ff <= 1'b0;
            perr_ff <= 1'b0;
            perrCode_ff <= '0;
        end else begin
            ps_ff <= nxt_ps;
            pfmt_ff <= nxt_pfmt;
            acc_ff <= nxt_acc;
            got_ff <= nxt_got;
            perr_ff <= nxt_perr;
            perrCode_ff <= nxt_perrCode;
        end
    end

    // Event and enable register sets: 0 std, 1 oper, 2 meas, 3 ques
    logic [REG_W-1:0] evt_ff [NUM_SETS];
    logic [REG_W-1:0] en_ff [NUM_SETS];
    wire [REG_W-1:0] setIn [NUM_SETS];
    wire [REG_W-1:0] condIn [NUM_SETS];
    assign setIn[0] = stdEvtSet;
    assign setIn[1] = operEvtSet;
    assign setIn[2] = measEvtSet;
    assign setIn[3] = quesEvtSet;
    assign condIn[0] = '0;
    assign condIn[1] = operCond;
    assign condIn[2] = measCond;
    assign condIn[3] = quesCond;

    for (genvar g = 0; g < NUM_SETS; g++) begin : g_set
        // A new event in the clearing cycle survives the clear
        wire [REG_W-1:0] nxt_evt = (clrEvents ? '0 : evt_ff[g]) |
            setIn[g];
        wire progHit = progOk & (cmdSet == 2'(g));
        wire presetHit = clrEvents & (2'(g) != SET_STD);
        wire [REG_W-1:0] nxt_en = progHit ? acc_ff :
            (presetHit ? '0 : en_ff[g]);
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                evt_ff[g] <= '0;
                en_ff[g] <= '0;
            end else begin
                evt_ff[g] <= nxt_evt;
                en_ff[g] <= nxt_en;
            end
        end
    end

    // Response generator
    srcp_rgen_t rg_ff, nxt_rg;
    srcp_fmt_t fmt_ff, qfmt_ff, nxt_qfmt;
    logic [REG_W-1:0] val_ff, nxt_val;
    logic [4:0] pos_ff, nxt_pos;
    logic [3:0] cnt_ff, nxt_cnt;
    logic started_ff, nxt_started, sub_ff, nxt_sub;
    logic respWrite;
    logic [7:0] respChar;

    wire busy = (rg_ff != RG_IDLE);
    wire queryCmd = cmdWr & (op == OP_QUERY);
    wire queryStart = queryCmd & ~busy;
    wire srcpFmtCmd = cmdWr & (op == OP_FORMAT);
    wire [REG_W-1:0] selVal = (cmdKind == KIND_COND) ? condIn[cmdSet] :
        (cmdKind == KIND_EVENT) ? evt_ff[cmdSet] :
        (cmdKind == KIND_ENABLE) ? en_ff[cmdSet] : '0;
    wire [7:0] shamt = 8'(pos_ff) * 8'(bitsOf(qfmt_ff));
    wire [REG_W-1:0] shifted = val_ff >> shamt;
    wire [3:0] p2Mask = 4'(radixOf(qfmt_ff) - 5'd1);
    wire [3:0] digit = (qfmt_ff == FMT_ASC) ? cnt_ff :
        (shifted[3:0] & p2Mask);
    wire lastPos = (pos_ff == '0);
    wire emit = (digit != '0) | started_ff | lastPos;
    wire [REG_W-1:0] pw = pow10(pos_ff);
    wire [7:0] digitChar = (digit < 4'd10) ? CH_0 + 8'(digit) :
        CH_A + 8'(digit) - 8'd10;

    always_comb begin
        nxt_rg = rg_ff;
        nxt_qfmt = qfmt_ff;
        nxt_val = val_ff;
        nxt_pos = pos_ff;
        nxt_cnt = cnt_ff;
        nxt_started = started_ff;
        nxt_sub = sub_ff;
        respWrite = 1'b0;
        respChar = CH_0;
        case (rg_ff)
            RG_IDLE: begin
                if (queryStart) begin
                    nxt_val = selVal;
                    nxt_qfmt = fmt_ff;
                    nxt_pos = digitsOf(fmt_ff) - 5'd1;
                    nxt_cnt = '0;
                    nxt_started = 1'b0;
                    nxt_sub = (fmt_ff == FMT_ASC);
                    nxt_rg = (fmt_ff == FMT_ASC) ? RG_DIGIT : RG_HASH;
                end
            end
            RG_HASH: begin
                respWrite = 1'b1;
                respChar = CH_HASH;
                nxt_rg = RG_LETTER;
            end
            RG_LETTER: begin
                respWrite = 1'b1;
                respChar = (qfmt_ff == FMT_BIN) ? CH_B :
                    (qfmt_ff == FMT_HEX) ? CH_H : CH_Q;
                nxt_rg = RG_DIGIT;
            end
            RG_DIGIT: begin
                if (sub_ff && val_ff >= pw) begin
                    nxt_val = val_ff - pw;
                    nxt_cnt = cnt_ff + 4'd1;
                end else begin
                    respWrite = emit;
                    respChar = digitChar;
                    nxt_started = started_ff | emit;
                    nxt_cnt = '0;
                    nxt_pos = pos_ff - 5'd1;
                    nxt_rg = lastPos ? RG_IDLE : RG_DIGIT;
                end
            end
            default: nxt_rg = RG_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rg_ff <= RG_IDLE;
            fmt_ff <= FMT_ASC;
            qfmt_ff <= FMT_ASC;
            val_ff <= '0;
            pos_ff <= '0;
            cnt_ff <= '0;
            started_ff <= 1'b0;
            sub_ff <= 1'b0;
        end else begin
            rg_ff <= nxt_rg;
            fmt_ff <= srcpFmtCmd ?
                srcp_fmt_t'(pwdata[CMD_FMT_LSB +: 2]) : fmt_ff;
            qfmt_ff <= nxt_qfmt;
            val_ff <= nxt_val;
            pos_ff <= nxt_pos;
            cnt_ff <= nxt_cnt;
            started_ff <= nxt_started;
            sub_ff <= nxt_sub;
        end
    end

    // Output queue holding the response characters
    logic [7:0] respMem [RESP_DEPTH];
    logic [RS_AW-1:0] rWr_ff, rRd_ff;
    logic [DATA_W-1:0] prdata_ff;
    wire respAvail = (rRd_ff < rWr_ff);
    wire respPop = rdAcc & (paddr == OFF_RESP) & prdata_ff[RESP_VALID_BIT];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rWr_ff <= '0;
            rRd_ff <= '0;
        end else begin
            rWr_ff <= queryStart ? '0 : rWr_ff + RS_AW'(respWrite);
            rRd_ff <= queryStart ? '0 : rRd_ff + RS_AW'(respPop);
        end
    end

    always_ff @(posedge clock) begin
        if (respWrite) begin
            respMem[rWr_ff] <= respChar;
        end
    end

    // Error queue; a push in the clearing cycle is kept
    logic [15:0] errMem [ERRQ_DEPTH];
    logic [EQ_AW-1:0] eqWr_ff, eqRd_ff;
    logic [EQ_AW:0] eqCnt_ff;
    wire progErr = progCmd & ~progOk;
    wire [15:0] progErrCode = (cmdKind != KIND_ENABLE) ? ERR_READ_ONLY :
        (perr_ff ? perrCode_ff : ERR_NO_DIGITS);
    wire intPush = progErr | (cmdWr & ~opKnown) | (queryCmd & busy);
    wire [15:0] intCode = progErr ? progErrCode :
        (queryCmd ? ERR_BUSY : ERR_BAD_CMD);
    wire push = intPush | errPushValid;
    wire [15:0] pushCode = intPush ? intCode : errPushCode;
    wire eqPop = rdAcc & (paddr == OFF_ERRQ) & prdata_ff[ERRQ_VALID_BIT] &
        ~errClr;
    wire [EQ_AW-1:0] eqWrBase = errClr ? '0 : eqWr_ff;
    wire [EQ_AW-1:0] eqRdBase = errClr ? '0 : eqRd_ff;
    wire [EQ_AW:0] eqCntBase = errClr ? '0 : eqCnt_ff;
    wire eqPush = push & ((eqCntBase != (EQ_AW+1)'(ERRQ_DEPTH)) | eqPop);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            eqWr_ff <= '0;
            eqRd_ff <= '0;
            eqCnt_ff <= '0;
        end else begin
            eqWr_ff <= eqWrBase + EQ_AW'(eqPush);
            eqRd_ff <= eqRdBase + EQ_AW'(eqPop);
            eqCnt_ff <= eqCntBase + (EQ_AW+1)'(eqPush) - (EQ_AW+1)'(eqPop);
        end
    end

    always_ff @(posedge clock) begin
        if (eqPush) begin
            errMem[eqWrBase] <= pushCode;
        end
    end

    // Read data is captured in the setup cycle
    wire [DATA_W-1:0] statusWord = (DATA_W'(fmt_ff) << ST_FMT_LSB) |
        (DATA_W'(perr_ff) << ST_PERR_BIT) | (DATA_W'(busy) << ST_BUSY_BIT) |
        (DATA_W'(rWr_ff - rRd_ff) << ST_RCNT_LSB) |
        (DATA_W'(eqCnt_ff) << ST_ECNT_LSB);
    wire [DATA_W-1:0] respWord = respAvail ?
        ((DATA_W'(1) << RESP_VALID_BIT) | DATA_W'(respMem[rRd_ff])) : '0;
    wire [DATA_W-1:0] errqWord = (eqCnt_ff != '0) ?
        ((DATA_W'(1) << ERRQ_VALID_BIT) | DATA_W'(errMem[eqRd_ff])) : '0;
    wire [DATA_W-1:0] rdMux = (paddr == OFF_STATUS) ? statusWord :
        (paddr == OFF_RESP) ? respWord :
        (paddr == OFF_ERRQ) ? errqWord : '0;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_ff <= '0;
        end else if (setup && !pwrite) begin
            prdata_ff <= rdMux;
        end
    end
    assign prdata = prdata_ff;
endmodule // srcp_status_regs

// ===== dv/srcp_status_regs_assertions.sv
`timescale 1ns/1ns
module srcp_status_regs_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [srcp_pkg::ADDR_W-1:0] paddr,
    input wire logic [srcp_pkg::DATA_W-1:0] pwdata,
    input wire logic [srcp_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import srcp_pkg::*;
    logic mapped;
    logic rdSetup;
    assign mapped = paddr == OFF_CMD || paddr == OFF_PCHAR ||
        paddr == OFF_RESP || paddr == OFF_STATUS || paddr == OFF_ERRQ;
    assign rdSetup = psel && !penable && !pwrite;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ready_high_a: assert property (pready == 1'b1)
        else $error("pready low");
    slverr_map_a: assert property (psel && penable
        |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    slverr_idle_a: assert property (!(psel && penable)
        |-> !pslverr)
        else $error("pslverr outside access phase");
    rdata_hold_a: assert property (!rdSetup |=> $stable(prdata))
        else $error("prdata moved without a read");
    unmap_zero_a: assert property (rdSetup && !mapped
        |=> prdata == '0)
        else $error("unmapped read not zero");
    reset_rdata_a: assert property ($rose(rst_n) |-> prdata == '0)
        else $error("prdata not cleared by reset");
    resp_shape_a: assert property (rdSetup && paddr == OFF_RESP
        |=> prdata[31:9] == '0) else $error("response word too wide");
    errq_shape_a: assert property (rdSetup && paddr == OFF_ERRQ
        |=> prdata[31:17] == '0) else $error("error word too wide");
    cover property (rdSetup && paddr == OFF_RESP);
    cover property (psel && penable && pwrite && paddr == OFF_CMD &&
        pwdata[3:0] == OP_PROGRAM);
    cover property (psel && penable && pslverr);
endmodule // srcp_status_regs_assertions
bind srcp_status_regs srcp_status_regs_assertions i_chk (.clock(clock),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// ===== dv/srcp_evt_src.sv
`timescale 1ns/1ns
module srcp_evt_src (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic [15:0] pat,
    output logic [15:0] operCond,
    output logic [15:0] measCond,
    output logic [15:0] quesCond,
    output logic [15:0] stdEvt,
    output logic [15:0] operEvt,
    output logic [15:0] measEvt,
    output logic [15:0] quesEvt,
    output logic errValid,
    output logic [15:0] errCode
);
    logic fire_ff;
    logic [15:0] pat_ff;
    always_ff @(posedge clock) begin
        fire_ff <= rst_n & fire;
        pat_ff <= pat;
    end
    // One-cycle event burst and error push per fire
    assign operCond = pat_ff;
    assign measCond = pat_ff;
    assign quesCond = pat_ff;
    assign stdEvt = fire_ff ? pat_ff : 16'h0000;
    assign operEvt = stdEvt;
    assign measEvt = stdEvt;
    assign quesEvt = stdEvt;
    assign errValid = fire_ff;
    assign errCode = pat_ff;
endmodule // srcp_evt_src

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb;
    import srcp_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m;} srcp_note_t;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'h81d296a5;
    logic pready, pslverr, fire = 0, errPushValid;
    logic [15:0] pat = '0, operCond, measCond, quesCond, errPushCode;
    logic [15:0] stdEvtSet, operEvtSet, measEvtSet, quesEvtSet;
    logic [1:0] fmt = 2'h0;
    int err_total = 0, n_checks = 0, cyc = 0;
    srcp_note_t expQ[$];
    srcp_note_t nt;
    string prm[8] = '{"#b101100", "#h2C", "#q54", "44", "#B1", "#H8000",
        "#Q177777", "0"};
    logic [15:0] pv[8] = '{16'h2c, 16'h2c, 16'h2c, 16'h2c, 16'h1,
        16'h8000, 16'hffff, 16'h0};
    initial forever #5 clock = ~clock;
    srcp_status_regs i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .operCond(operCond), .measCond(measCond), .quesCond(quesCond),
        .stdEvtSet(stdEvtSet), .operEvtSet(operEvtSet),
        .measEvtSet(measEvtSet), .quesEvtSet(quesEvtSet),
        .errPushValid(errPushValid), .errPushCode(errPushCode));
    srcp_evt_src i_src (.clock(clock), .rst_n(rst_n), .fire(fire),
        .pat(pat), .operCond(operCond), .measCond(measCond),
        .quesCond(quesCond), .stdEvt(stdEvtSet), .operEvt(operEvtSet),
        .measEvt(measEvtSet), .quesEvt(quesEvtSet),
        .errValid(errPushValid), .errCode(errPushCode));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic string resp(input logic [15:0] v);
        string s;
        case (fmt)
            2'h1: s = $sformatf("#H%0h", v);
            2'h2: s = $sformatf("#Q%0o", v);
            2'h3: s = $sformatf("#B%0b", v);
            default: s = $sformatf("%0d", v);
        endcase
        return s.toupper();
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1 && !pwrite &&
            expQ.size() > 0) begin
            nt = expQ.pop_front();
            if (nt.m !== '0) begin
                n_checks++;
                if ((prdata & nt.m) !== (nt.v & nt.m)) begin
                    err_total++;
                    $display("BAD t=%0t exp=%h got=%h", $time,
                        nt.v & nt.m, prdata & nt.m);
                end
            end
        end
        if (cyc == 30000) begin
            err_total++;
            conclude();
        end
    end
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] v, m);
        expQ.push_back('{v, m});
        xfer(a, 1'b0, 32'h0);
    endtask
    task automatic cmd(input logic [3:0] op, input logic [1:0] s = 0,
        input logic [1:0] k = 0);
        wr(OFF_CMD, {22'h0, fmt, k, s, op});
    endtask
    task automatic prog(input logic [1:0] s, input string p,
        input logic [1:0] k = KIND_ENABLE);
        for (int i = 0; i < p.len(); i++) wr(OFF_PCHAR, {24'h0, p[i]});
        cmd(OP_PROGRAM, s, k);
    endtask
    task automatic qry(input logic [1:0] s, k, input logic [15:0] v);
        string e;
        e = resp(v);
        cmd(OP_QUERY, s, k);
        do begin
            rdc(OFF_STATUS, 0, 0);
        end while (rd[ST_BUSY_BIT] !== 1'b0);
        for (int i = 0; i < e.len(); i++)
            rdc(OFF_RESP, {23'h0, 1'b1, e[i]}, 32'h1ff);
        rdc(OFF_RESP, 0, 32'h100);
    endtask
    task automatic ecnt(input logic [7:0] n);
        rdc(OFF_STATUS, {8'h0, n, 16'h0}, 32'hff0000);
    endtask
    task automatic pulse();
        seed = lfsr(seed);
        pat <= seed[15:0];
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdc(OFF_STATUS, 0, 32'hffff0f);
        rdc(OFF_ERRQ, 0, 32'h10000);
        for (int s = 0; s < 4; s++) qry(2'(s), KIND_EVENT, 0);
        qry(2'h1, KIND_ENABLE, 0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            fmt = 2'(i);
            cmd(OP_FORMAT);
            rdc(OFF_STATUS, 32'(i % 4), 32'h3);
            prog(2'(i), prm[i]);
            qry(2'(i), KIND_ENABLE, pv[i]);
        end
        seed = lfsr(seed);
        prog(2'h1, $sformatf("%0d", seed[15:0]));
        qry(2'h1, KIND_ENABLE, seed[15:0]);
        prog(2'h1, "#B102");
        rdc(OFF_ERRQ, {15'h0, 1'b1, ERR_BAD_DIGIT}, 32'h1ffff);
        prog(2'h1, "#q78");
        rdc(OFF_ERRQ, {15'h0, 1'b1, ERR_BAD_DIGIT}, 32'h1ffff);
        prog(2'h1, "5", KIND_EVENT);
        rdc(OFF_ERRQ, {15'h0, 1'b1, ERR_READ_ONLY}, 32'h1ffff);
        prog(2'h1, "#x1");
        rdc(OFF_ERRQ, {15'h0, 1'b1, ERR_BAD_HEADER}, 32'h1ffff);
        qry(2'h1, KIND_ENABLE, seed[15:0]);
        wr(OFF_STATUS, '1);
        wr(8'h40, '1);
        rdc(8'h40, 0, '1);
        $display("test program done");
        prog(2'h0, "#H5");
        prog(2'h1, "7");
        pulse();
        cmd(OP_RST);
        cmd(OP_SYS_PRESET);
        for (int s = 0; s < 4; s++) qry(2'(s), KIND_EVENT, pat);
        for (int s = 1; s < 4; s++) qry(2'(s), KIND_COND, pat);
        qry(2'h1, KIND_ENABLE, 16'h7);
        ecnt(8'h1);
        cmd(OP_STAT_PRESET);
        for (int s = 0; s < 4; s++) qry(2'(s), KIND_EVENT, 0);
        for (int s = 1; s < 4; s++) qry(2'(s), KIND_ENABLE, 0);
        qry(2'h0, KIND_ENABLE, 16'h5);
        ecnt(8'h1);
        cmd(OP_CLS);
        ecnt(8'h0);
        qry(2'h0, KIND_ENABLE, 16'h5);
        pulse();
        cmd(OP_QUEUE_CLR);
        ecnt(8'h0);
        pulse();
        cmd(OP_ERR_CLR);
        ecnt(8'h0);
        $display("test clear done");
        conclude();
    end
endmodule // tb
